/* logic/floppy_cfg_regs.vh */
// Constants for the floppy configuration register bank: indexes, fields,
// reset values. Assumes inclusion by bare name from logic/ modules.
`ifndef FLOPPY_CFG_REGS_VH
`define FLOPPY_CFG_REGS_VH

// ----------------------------------------
// Register indexes
// ----------------------------------------
`define IDX_MODE      8'hf0
`define IDX_OPTION    8'hf1
`define IDX_TYPE      8'hf2
`define IDX_ZERO      8'hf3
`define IDX_DRIVE0    8'hf4
`define IDX_DRIVE1    8'hf5

// ----------------------------------------
// Reset values and writable masks
// ----------------------------------------
`define RST_MODE      8'h0e
`define RST_OPTION    8'h00
`define RST_TYPE      8'hff
`define RST_DRIVE     8'h00
`define MASK_MODE     8'hcf
`define MASK_OPTION   8'h0d
`define MASK_TYPE     8'hff
`define MASK_DRIVE    8'h5b

// ----------------------------------------
// Field positions
// ----------------------------------------
`define B_FLOPPY_MODE 0
`define B_DMA_MODE    1
`define B_IFMODE_LO   2
`define B_IFMODE_HI   3
`define B_OUT_TYPE    6
`define B_OUT_TRI     7
`define B_FORCE_WP    0
`define B_DENS_LO     2
`define B_DENS_HI     3
`define B_PRECOMP_DIS 6

// Interface mode and density encodings
`define IFM_A         2'h3
`define IFM_RSVD      2'h2
`define IFM_B         2'h1
`define IFM_C         2'h0
`define DENS_FORCE1   2'h2
`define DENS_FORCE0   2'h3

`endif

/* logic/cfg_byte_reg.v */
// One configuration byte with reset default and write mask.
// Assumes reset comes synchronised from the top.
`timescale 1ns/1ps
module cfg_byte_reg #(
    parameter [7:0] RESET_VAL = 8'h00,
    parameter [7:0] WR_MASK   = 8'hff
) (
    input  wire       clk,
    input  wire       rst_n,
    input  wire       ce,
    input  wire       wr_en,
    input  wire [7:0] wr_data,
    output wire [7:0] q
);
    reg [7:0] val_r;
    wire [7:0] val_nxt;

    // Bits outside WR_MASK never change, so they keep reading as their RESET_VAL bits
    assign val_nxt = (val_r & ~WR_MASK) | (wr_data & WR_MASK);

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            val_r <= RESET_VAL;
        end else if (ce && wr_en) begin
            val_r <= val_nxt;
        end
    end

    assign q = val_r;
endmodule // cfg_byte_reg

/* logic/floppy_pin_sync.v */
// Three-stage synchroniser for pin inputs; output changes once the
// second and third stages agree. Assumes a single clock domain.
`timescale 1ns/1ps
module floppy_pin_sync #(
    parameter [0:0] RESET_VAL = 1'b1
) (
    input  wire clk,
    input  wire rst_n,
    input  wire ce,
    input  wire pin,
    output wire q
);
    reg s1_r;
    reg s2_r;
    reg s3_r;
    reg out_r;

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s1_r  <= RESET_VAL;
            s2_r  <= RESET_VAL;
            s3_r  <= RESET_VAL;
            out_r <= RESET_VAL;
        end else if (ce) begin
            s1_r <= pin;
            s2_r <= s1_r;
            s3_r <= s2_r;
            if (s2_r == s3_r) begin
                out_r <= s3_r;
            end
        end
    end

    assign q = out_r;
endmodule // floppy_pin_sync

/* logic/floppy_cfg_bank.v */
// Floppy configuration register bank reached via index/data port pair,
// plus write-protect combining and pin buffer controls.
// Assumes index/data decoding upstream presents a selected-device strobe.
`timescale 1ns/1ps
`include "floppy_cfg_regs.vh"
module floppy_cfg_bank (
    input  wire       CLK,
    input  wire       RST_N,
    input  wire       CE,
    input  wire       HARD_RESET,
    input  wire       CFG_SEL,
    input  wire [7:0] CFG_INDEX,
    input  wire       CFG_WR,
    input  wire       CFG_RD,
    input  wire [7:0] CFG_WDATA,
    output reg  [7:0] CFG_RDATA,
    input  wire       FLOPPY_WP_GLOBAL,
    input  wire       WRITE_PROTECT_INPUT_N,
    input  wire       DRIVE_SELECT_FIRST_N,
    input  wire       DRIVE_SELECT_SECOND_N,
    input  wire       PP_DRIVE_SELECT_FIRST_N,
    input  wire       PP_DRIVE_SELECT_SECOND_N,
    input  wire       CORE_DENSITY,
    input  wire [7:0] CORE_PIN_OUT,
    output wire       WRITE_PROTECT_N,
    output wire       STATUS_REGISTER_A_WP,
    output wire       ENHANCED_FLOPPY_MODE_TWO,
    output wire       DMA_BURST_EN,
    output wire       INTERFACE_MODE_A,
    output wire       INTERFACE_MODE_B,
    output wire       INTERFACE_MODE_C,
    output wire       DENSITY_OUT,
    output reg  [7:0] FLOPPY_PIN_OUT,
    output reg  [7:0] FLOPPY_PIN_OE,
    output wire       PUSH_PULL_OUTPUT_BUFFER,
    output wire       PP_PIN_OE_UNAFFECTED,
    output wire [1:0] DRIVE_TYPE_SELECT_0,
    output wire [1:0] DATA_RATE_TABLE_SELECT_0,
    output wire       PRECOMP_DISABLE_0,
    output wire [1:0] DRIVE_TYPE_SELECT_1,
    output wire [1:0] DATA_RATE_TABLE_SELECT_1,
    output wire       PRECOMP_DISABLE_1,
    output wire [1:0] DRIVE_A_TYPE,
    output wire [1:0] DRIVE_B_TYPE
);
    // ----------------------------------------
    // Reset synchroniser
    // ----------------------------------------
    // Power-on (RST_N) and hard reset both restore defaults; soft reset
    // is not an input here so it cannot disturb these registers.
    wire rst_src_n;
    reg  rst_s1_r;
    reg  rst_s2_r;
    wire rst_n;
    reg  hard_rst_r;

    assign rst_src_n = RST_N & ~hard_rst_r;

    // Hard reset is registered so the async reset has a clean source
    always @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            hard_rst_r <= 1'b0;
        end else begin
            hard_rst_r <= HARD_RESET;
        end
    end

    always @(posedge CLK or negedge rst_src_n) begin
        if (!rst_src_n) begin
            rst_s1_r <= 1'b0;
            rst_s2_r <= 1'b0;
        end else begin
            rst_s1_r <= 1'b1;
            rst_s2_r <= rst_s1_r;
        end
    end

    assign rst_n = rst_s2_r;

    // ----------------------------------------
    // Register writes
    // ----------------------------------------
    wire       wr_ok;
    wire [7:0] mode_q;
    wire [7:0] opt_q;
    wire [7:0] type_q;
    wire [7:0] drv0_q;
    wire [7:0] drv1_q;

    assign wr_ok = CFG_SEL & CFG_WR;

    cfg_byte_reg #(.RESET_VAL(`RST_MODE), .WR_MASK(`MASK_MODE)) u_mode (
        .clk     (CLK),
        .rst_n   (rst_n),
        .ce      (CE),
        .wr_en   (wr_ok && CFG_INDEX == `IDX_MODE),
        .wr_data (CFG_WDATA),
        .q       (mode_q)
    );

    cfg_byte_reg #(.RESET_VAL(`RST_OPTION), .WR_MASK(`MASK_OPTION)) u_opt (
        .clk     (CLK),
        .rst_n   (rst_n),
        .ce      (CE),
        .wr_en   (wr_ok && CFG_INDEX == `IDX_OPTION),
        .wr_data (CFG_WDATA),
        .q       (opt_q)
    );

    // All four type fields are plain storage
    cfg_byte_reg #(.RESET_VAL(`RST_TYPE), .WR_MASK(`MASK_TYPE)) u_type (
        .clk     (CLK),
        .rst_n   (rst_n),
        .ce      (CE),
        .wr_en   (wr_ok && CFG_INDEX == `IDX_TYPE),
        .wr_data (CFG_WDATA),
        .q       (type_q)
    );

    cfg_byte_reg #(.RESET_VAL(`RST_DRIVE), .WR_MASK(`MASK_DRIVE)) u_drv0 (
        .clk     (CLK),
        .rst_n   (rst_n),
        .ce      (CE),
        .wr_en   (wr_ok && CFG_INDEX == `IDX_DRIVE0),
        .wr_data (CFG_WDATA),
        .q       (drv0_q)
    );

    cfg_byte_reg #(.RESET_VAL(`RST_DRIVE), .WR_MASK(`MASK_DRIVE)) u_drv1 (
        .clk     (CLK),
        .rst_n   (rst_n),
        .ce      (CE),
        .wr_en   (wr_ok && CFG_INDEX == `IDX_DRIVE1),
        .wr_data (CFG_WDATA),
        .q       (drv1_q)
    );

    // ----------------------------------------
    // Register reads
    // ----------------------------------------
    reg [7:0] rd_nxt;

    always @* begin
        case (CFG_INDEX)
            `IDX_MODE:   rd_nxt = mode_q;
            `IDX_OPTION: rd_nxt = opt_q;
            `IDX_TYPE:   rd_nxt = type_q;
            `IDX_ZERO:   rd_nxt = 8'h00;
            `IDX_DRIVE0: rd_nxt = drv0_q;
            `IDX_DRIVE1: rd_nxt = drv1_q;
            default:     rd_nxt = 8'h00;
        endcase
    end

    always @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            CFG_RDATA <= 8'h00;
        end else if (CE && CFG_SEL && CFG_RD) begin
            CFG_RDATA <= rd_nxt;
        end
    end

    // ----------------------------------------
    // Pin input synchronisers
    // ----------------------------------------
    wire wp_in_n;
    wire ds0_n;
    wire ds1_n;
    wire pp_ds0_n;
    wire pp_ds1_n;

    floppy_pin_sync u_sync_wp (
        .clk   (CLK),
        .rst_n (rst_n),
        .ce    (CE),
        .pin   (WRITE_PROTECT_INPUT_N),
        .q     (wp_in_n)
    );

    floppy_pin_sync u_sync_ds0 (
        .clk   (CLK),
        .rst_n (rst_n),
        .ce    (CE),
        .pin   (DRIVE_SELECT_FIRST_N),
        .q     (ds0_n)
    );

    floppy_pin_sync u_sync_ds1 (
        .clk   (CLK),
        .rst_n (rst_n),
        .ce    (CE),
        .pin   (DRIVE_SELECT_SECOND_N),
        .q     (ds1_n)
    );

    floppy_pin_sync u_sync_pds0 (
        .clk   (CLK),
        .rst_n (rst_n),
        .ce    (CE),
        .pin   (PP_DRIVE_SELECT_FIRST_N),
        .q     (pp_ds0_n)
    );

    floppy_pin_sync u_sync_pds1 (
        .clk   (CLK),
        .rst_n (rst_n),
        .ce    (CE),
        .pin   (PP_DRIVE_SELECT_SECOND_N),
        .q     (pp_ds1_n)
    );

    // ----------------------------------------
    // Write-protect combining
    // ----------------------------------------
    // Active-high terms; selects and protect input are active low
    wire force_wp;
    wire sel0;
    wire sel1;
    wire wp_act;

    assign force_wp = opt_q[`B_FORCE_WP];
    // Selects from the parallel-port pins count as well
    assign sel0 = ~ds0_n | ~pp_ds0_n;
    assign sel1 = ~ds1_n | ~pp_ds1_n;
    assign wp_act = FLOPPY_WP_GLOBAL | ~wp_in_n | (sel0 & force_wp)
                    | (sel1 & force_wp);
    assign WRITE_PROTECT_N      = ~wp_act;
    assign STATUS_REGISTER_A_WP = wp_act;

    // ----------------------------------------
    // Mode decode
    // ----------------------------------------
    wire [1:0] if_mode;

    assign ENHANCED_FLOPPY_MODE_TWO = mode_q[`B_FLOPPY_MODE];
    assign DMA_BURST_EN = ~mode_q[`B_DMA_MODE];
    assign if_mode = mode_q[`B_IFMODE_HI:`B_IFMODE_LO];
    // Reserved code selects no personality
    assign INTERFACE_MODE_A = (if_mode == `IFM_A);
    assign INTERFACE_MODE_B = (if_mode == `IFM_B);
    assign INTERFACE_MODE_C = (if_mode == `IFM_C);

    // ----------------------------------------
    // Density override
    // ----------------------------------------
    wire [1:0] dens_sel;

    assign dens_sel = opt_q[`B_DENS_HI:`B_DENS_LO];
    assign DENSITY_OUT = (dens_sel == `DENS_FORCE1) ? 1'b1 :
                         (dens_sel == `DENS_FORCE0) ? 1'b0 : CORE_DENSITY;

    // ----------------------------------------
    // Dedicated pin buffers
    // ----------------------------------------
    wire push_pull;
    wire tri_all;
    integer i;

    assign push_pull = mode_q[`B_OUT_TYPE];
    assign tri_all   = mode_q[`B_OUT_TRI];
    assign PUSH_PULL_OUTPUT_BUFFER = push_pull;

    // Open drain drives only low; push-pull drives both levels
    always @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            FLOPPY_PIN_OUT <= 8'h00;
            FLOPPY_PIN_OE  <= 8'h00;
        end else if (CE) begin
            FLOPPY_PIN_OUT <= CORE_PIN_OUT;
            for (i = 0; i < 8; i = i + 1) begin
                FLOPPY_PIN_OE[i] <= ~tri_all & (push_pull | ~CORE_PIN_OUT[i]);
            end
        end
    end

    // Parallel-port floppy pins get no buffer control from here
    assign PP_PIN_OE_UNAFFECTED = 1'b1;

    // ----------------------------------------
    // Per-drive selects
    // ----------------------------------------
    assign DRIVE_TYPE_SELECT_0      = drv0_q[1:0];
    assign DATA_RATE_TABLE_SELECT_0 = drv0_q[4:3];
    assign PRECOMP_DISABLE_0        = drv0_q[`B_PRECOMP_DIS];
    assign DRIVE_TYPE_SELECT_1      = drv1_q[1:0];
    assign DATA_RATE_TABLE_SELECT_1 = drv1_q[4:3];
    assign PRECOMP_DISABLE_1        = drv1_q[`B_PRECOMP_DIS];
    // Only drives A and B reach the outside; C and D stay stored
    assign DRIVE_A_TYPE = type_q[1:0];
    assign DRIVE_B_TYPE = type_q[3:2];
endmodule // floppy_cfg_bank

/* verif/floppy_cfg_bank_checker.sv */
// Checker for the floppy configuration bank ports.
// Assumes one clock domain; bound to the bank below.
`timescale 1ns/1ps
module floppy_cfg_bank_checker (
    input wire       CLK,
    input wire       RST_N,
    input wire       CE,
    input wire       HARD_RESET,
    input wire       CFG_SEL,
    input wire [7:0] CFG_INDEX,
    input wire       CFG_WR,
    input wire       CFG_RD,
    input wire [7:0] CFG_WDATA,
    input wire [7:0] CFG_RDATA,
    input wire       FLOPPY_WP_GLOBAL,
    input wire       WRITE_PROTECT_N,
    input wire       ENHANCED_FLOPPY_MODE_TWO,
    input wire       DMA_BURST_EN,
    input wire       INTERFACE_MODE_A,
    input wire       PUSH_PULL_OUTPUT_BUFFER,
    input wire       DENSITY_OUT,
    input wire [1:0] DRIVE_TYPE_SELECT_0
);
    // ------------------------------------
    // Write decodes and assertions
    // ------------------------------------
    default clocking @(posedge CLK); endclocking
    default disable iff (!RST_N);
    wire wr_go = CE && CFG_SEL && CFG_WR;
    wire wr0   = wr_go && CFG_INDEX == 8'hf0;
    wire wr1   = wr_go && CFG_INDEX == 8'hf1;
    wire wr4   = wr_go && CFG_INDEX == 8'hf4;
    chk_mode_bits: assert property (wr0 |=>
        ENHANCED_FLOPPY_MODE_TWO == $past(CFG_WDATA[0]) && DMA_BURST_EN == !$past(CFG_WDATA[1]))
        else $error("mode bits not applied");
    chk_iface_a: assert property (wr0 |=>
        INTERFACE_MODE_A == ($past(CFG_WDATA[3:2]) == 2'h3)) else $error("mode A decode wrong");
    chk_push_pull: assert property (wr0 |=>
        PUSH_PULL_OUTPUT_BUFFER == $past(CFG_WDATA[6])) else $error("buffer type wrong");
    chk_zero_read: assert property (
        CE && CFG_SEL && CFG_RD && CFG_INDEX == 8'hf3 |=> CFG_RDATA == 8'h00)
        else $error("zero slot not zero");
    chk_wp_global: assert property (FLOPPY_WP_GLOBAL |-> !WRITE_PROTECT_N)
        else $error("global protect ignored");
    chk_hard_dflt: assert property ($rose(HARD_RESET) |-> ##2
        !DMA_BURST_EN && INTERFACE_MODE_A && !ENHANCED_FLOPPY_MODE_TWO)
        else $error("hard reset default missing");
    chk_dens_force: assert property (wr1 && CFG_WDATA[3:2] == 2'h2 |=> DENSITY_OUT)
        else $error("density not forced high");
    chk_drive_type: assert property (wr4 |=>
        DRIVE_TYPE_SELECT_0 == $past(CFG_WDATA[1:0])) else $error("drive type wrong");
    cover property (wr0);
    cover property ($rose(HARD_RESET));
    cover property (wr1 && CFG_WDATA[0]);
endmodule // floppy_cfg_bank_checker

bind floppy_cfg_bank floppy_cfg_bank_checker chk_i (.*);

/* verif/floppy_drive_model.sv */
// Drive-side model: a drive whose write-protect pin answers when selected.
// Assumes a pull-up on the pin, so a deselected drive reads high.
`timescale 1ns/1ps
module floppy_drive_model (
    input  wire sel_n,
    input  wire tab,
    output wire wp_n
);
    // Deselected drive releases the pin to the pull-up level
    assign wp_n = !(!sel_n && tab);
endmodule // floppy_drive_model

/* verif/floppy_cfg_bank_test.sv */
// Testbench for the floppy configuration bank.
// Assumes the drive model on the write-protect pin; CE is driven here.
`timescale 1ns/1ps
module floppy_cfg_bank_test;
    reg        clk = 0, rst_n = 0, hard = 0, sel = 0, wr = 0, rd = 0, wpg = 0;
    reg        ds0_n = 1, ds1_n = 1, pp0_n = 1, pp1_n = 1, cden = 0, tab = 0, ce = 1;
    reg  [7:0] idx = 8'h00, wd = 8'h00, cpo = 8'h00;
    wire [7:0] rdata, oe, fo;
    wire       wpin_n, wp_n, status_register_a, enh, burst, ma, mb, mc, dens, pp, pp_ok, pc0, pc1;
    wire [1:0] dt0, dr0, dt1, dr1, dta, dtb;
    integer    errors = 0, tests_run = 0, i;
    floppy_cfg_bank DUT (.CLK(clk), .RST_N(rst_n), .CE(ce), .HARD_RESET(hard),
        .CFG_SEL(sel), .CFG_INDEX(idx), .CFG_WR(wr), .CFG_RD(rd), .CFG_WDATA(wd),
        .CFG_RDATA(rdata), .FLOPPY_WP_GLOBAL(wpg), .WRITE_PROTECT_INPUT_N(wpin_n),
        .DRIVE_SELECT_FIRST_N(ds0_n), .DRIVE_SELECT_SECOND_N(ds1_n),
        .PP_DRIVE_SELECT_FIRST_N(pp0_n), .PP_DRIVE_SELECT_SECOND_N(pp1_n),
        .CORE_DENSITY(cden), .CORE_PIN_OUT(cpo), .WRITE_PROTECT_N(wp_n),
        .STATUS_REGISTER_A_WP(status_register_a), .ENHANCED_FLOPPY_MODE_TWO(enh), .DMA_BURST_EN(burst),
        .INTERFACE_MODE_A(ma), .INTERFACE_MODE_B(mb), .INTERFACE_MODE_C(mc),
        .DENSITY_OUT(dens), .FLOPPY_PIN_OUT(fo), .FLOPPY_PIN_OE(oe),
        .PUSH_PULL_OUTPUT_BUFFER(pp), .PP_PIN_OE_UNAFFECTED(pp_ok),
        .DRIVE_TYPE_SELECT_0(dt0), .DATA_RATE_TABLE_SELECT_0(dr0), .PRECOMP_DISABLE_0(pc0),
        .DRIVE_TYPE_SELECT_1(dt1), .DATA_RATE_TABLE_SELECT_1(dr1),
        .PRECOMP_DISABLE_1(pc1), .DRIVE_A_TYPE(dta), .DRIVE_B_TYPE(dtb));
    floppy_drive_model drive (.sel_n(ds0_n), .tab(tab), .wp_n(wpin_n));
    always #50 clk = ~clk;
    // ------------------------------------
    // Shared tasks
    // ------------------------------------
    task chk(input [63:0] nm, input [7:0] e, input [7:0] g);
        begin
            tests_run = tests_run + 1;
            if (g !== e) begin
                $display("BAD %0s exp %h got %h", nm, e, g);
                errors = errors + 1;
            end
        end
    endtask
    task cyc(input integer n);
        repeat (n) @(negedge clk);
    endtask
    task acc(input w, input [7:0] a, input [7:0] d);
        begin
            @(negedge clk);
            sel = 1;
            wr = w;
            rd = !w;
            idx = a;
            wd = d;
            @(negedge clk);
            sel = 0;
            wr = 0;
            rd = 0;
        end
    endtask
    task rdchk(input [7:0] a, input [7:0] e);
        begin
            acc(0, a, 8'h00);
            chk("rdata", e, rdata);
        end
    endtask
    task stop_test;
        begin
            $display("checks %0d mismatches %0d", tests_run, errors);
            if (errors == 0 && tests_run > 0)
                $display("ALL CHECKS OK");
            else
                $display("CHECKS NOT OK");
            $finish;
        end
    endtask
    // ------------------------------------
    // Scenarios
    // ------------------------------------
    task t_masks;
        begin
            for (i = 0; i < 7; i = i + 1)
                acc(1, 8'hf0 + i[7:0], 8'hff);
            rdchk(8'hf0, 8'hcf);
            rdchk(8'hf1, 8'h0d);
            rdchk(8'hf2, 8'hff);
            rdchk(8'hf3, 8'h00);
            rdchk(8'hf4, 8'h5b);
            rdchk(8'hf5, 8'h5b);
            rdchk(8'hf6, 8'h00);
            chk("dt1", 8'h03, dt1);
            chk("dr1", 8'h03, dr1);
            chk("pc1", 8'h01, pc1);
            chk("dt0", 8'h03, dt0);
            chk("dr0", 8'h03, dr0);
            chk("pc0", 8'h01, pc0);
            $display("t_masks done");
        end
    endtask
    task t_hard;
        begin
            acc(1, 8'hf2, 8'h00);
            chk("typea", 8'h00, dta);
            chk("typeb", 8'h00, dtb);
            hard = 1;
            cyc(2);
            hard = 0;
            cyc(4);
            rdchk(8'hf0, 8'h0e);
            rdchk(8'hf1, 8'h00);
            rdchk(8'hf2, 8'hff);
            rdchk(8'hf5, 8'h00);
            chk("typea", 8'h03, dta);
            chk("typeb", 8'h03, dtb);
            // A write with the clock enable low must leave the bank frozen
            ce = 0;
            acc(1, 8'hf2, 8'h00);
            ce = 1;
            rdchk(8'hf2, 8'hff);
            $display("t_hard done");
        end
    endtask
    task t_modes;
        begin
            for (i = 0; i < 4; i = i + 1) begin
                acc(1, 8'hf0, {4'h0, i[1:0], i[0], !i[0]});
                chk("mode_a", i == 3, ma);
                chk("mode_b", i == 1, mb);
                chk("mode_c", i == 0, mc);
                chk("enh", !i[0], enh);
                chk("burst", !i[0], burst);
            end
            $display("t_modes done");
        end
    endtask
    task t_pins;
        begin
            cpo = 8'h5a;
            acc(1, 8'hf0, 8'h0e);
            cyc(1);
            chk("oe_od", 8'ha5, oe);
            chk("pin_out", 8'h5a, fo);
            acc(1, 8'hf0, 8'h4e);
            cyc(1);
            chk("oe_pp", 8'hff, oe);
            chk("pp", 8'h01, pp);
            acc(1, 8'hf0, 8'hce);
            cyc(1);
            chk("oe_tri", 8'h00, oe);
            chk("pp_oe", 8'h01, pp_ok);
            $display("t_pins done");
        end
    endtask
    task t_dens;
        begin
            for (i = 0; i < 8; i = i + 1) begin
                cden = i[2];
                acc(1, 8'hf1, {4'h0, i[1:0], 2'b00});
                chk("dens", i[1:0] == 2 ? 1'b1 : i[1:0] == 3 ? 1'b0 : i[2], dens);
            end
            $display("t_dens done");
        end
    endtask
    task t_wp;
        begin
            acc(1, 8'hf1, 8'h01);
            ds1_n = 0;
            cyc(5);
            chk("wp_ds1", 8'h00, wp_n);
            chk("sra", 8'h01, status_register_a);
            ds1_n = 1;
            pp0_n = 0;
            cyc(5);
            chk("wp_pp", 8'h00, wp_n);
            pp0_n = 1;
            acc(1, 8'hf1, 8'h00);
            ds0_n = 0;
            cyc(5);
            chk("wp_sel", 8'h01, wp_n);
            chk("sra_off", 8'h00, status_register_a);
            tab = 1;
            cyc(5);
            chk("wp_ext", 8'h00, wp_n);
            tab = 0;
            ds0_n = 1;
            wpg = 1;
            cyc(5);
            chk("wp_glob", 8'h00, wp_n);
            wpg = 0;
            $display("t_wp done");
        end
    endtask
    initial begin
        cyc(20);
        rst_n = 1;
        cyc(4);
        t_masks;
        t_hard;
        t_modes;
        t_pins;
        t_dens;
        t_wp;
        stop_test;
    end
    initial begin
        #2000000;
        errors = errors + 1;
        stop_test;
    end
endmodule // floppy_cfg_bank_test
